// ---- shared/board_irq_params.svh ----
// offsets, bit positions, reset values and response codes of the board status block
`ifndef BOARD_IRQ_PARAMS_SVH
`define BOARD_IRQ_PARAMS_SVH

// register indices; byte address is four times the index
`define BIS_STATUS_IDX      8'h08
`define BIS_CONTROL_IDX     8'h0a

// control register bit positions
`define BIS_CTRL_WON_EN_BIT 1
`define BIS_CTRL_TC_EN_BIT  2

// reset values
`define BIS_ENABLE_RESET    1'b0
`define BIS_CAUSE_RESET     4'h0
`define BIS_RDATA_RESET     32'h0000_0000

// axi4-lite responses
`define BIS_RESP_OKAY       2'h0
`define BIS_RESP_SLVERR     2'h2

// default byte address width
`define BIS_ADDR_W          8

`endif

// ---- shared/board_irq_pkg.sv ----
// types shared by the board status block
`default_nettype none

package board_irq_pkg;

    // status word as software sees it, bit 11 down to bit 0
    typedef struct packed {
        logic [3:0] exc_cause;
        logic       board_irq_summary;
        logic       remote_irq_hi;
        logic       unused_5;
        logic       remote_irq_seen;
        logic       master_exception_flag;
        logic       terminal_count_flag;
        logic       bus_won_flag;
        logic       signal_fifo_ready;
    } status_t;

    // board-side conditions, all synchronous to aclk
    typedef struct packed {
        logic       remote_irq;
        logic       exc_pulse;
        logic [3:0] exc_cause;
        logic       dma_tc_pulse;
        logic       arb_won_pulse;
        logic       sig_fifo_nonempty;
    } events_t;

    // register selection, one-hot
    typedef enum logic [2:0] {
        SEL_NONE    = 3'b001,
        SEL_STATUS  = 3'b010,
        SEL_CONTROL = 3'b100
    } reg_sel_t;

endpackage

`default_nettype wire

// ---- core/event_flag.sv ----
// sticky event flag gated by an enable
`timescale 1ns/1ns
`default_nettype none

module event_flag (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control
    input  wire logic enable,
    input  wire logic set,
    input  wire logic clear,
    // state
    output var  logic flag_q
);

    logic flag_d;

    // a set arriving with a clear wins; a dropped enable wipes the flag
    assign flag_d = enable && (set || (flag_q && !clear));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    a_set_wins_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && set |=> flag_q)
        else $error("flag lost a set");

    a_disable_wipes: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> !flag_q)
        else $error("flag survived its enable");

endmodule

`default_nettype wire

// ---- core/board_interrupt_status.sv ----
// board interrupt status register with control enables on an axi4-lite slave
//
// Function
// - status bit 4 shows the live remote interrupt request level.
// - status bits 4 and 6 always read the same remote request.
// - bit 3 sets when the last master transfer ended in an exception.
// - exception cause is kept in status bits 11 to 8.
// - reading the byte with the cause bits clears the exception flag.
// - bit 2 sets on final dma transfer while its enable is set.
// - clearing the terminal count enable or reset clears bit 2.
// - bit 1 sets on winning bus arbitration while its enable is set.
// - clearing the bus-won enable or reset clears bit 1.
// - bit 0 reads 1 while the signal fifo holds unread data.
// - bit 0 reads 0 while the signal fifo is empty.
// - bit 7 is the or of status bits 6 to 0.
// - enables live in a write-only control register at index 0a.
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "board_irq_params.svh"

module board_interrupt_status #(
    parameter int ADDR_W = `BIS_ADDR_W
) (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]      awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   awvalid,
    output var  logic                   awready,
    // axi4-lite write data
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output var  logic                   wready,
    // axi4-lite write response
    output var  logic [1:0]             bresp,
    output var  logic                   bvalid,
    input  wire logic                   bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0]      araddr,
    input  wire logic [2:0]             arprot,
    input  wire logic                   arvalid,
    output var  logic                   arready,
    // axi4-lite read data
    output var  logic [31:0]            rdata,
    output var  logic [1:0]             rresp,
    output var  logic                   rvalid,
    input  wire logic                   rready,
    // board conditions
    input  wire board_irq_pkg::events_t ev,
    output var  logic                   board_irq_summary
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check and decode

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 8 and 32");
    end

    // aligned word decode; low two address bits are ignored
    function automatic board_irq_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] a);
        if (a[ADDR_W-1:2] == (ADDR_W-2)'(`BIS_STATUS_IDX)) begin
            return board_irq_pkg::SEL_STATUS;
        end else if (a[ADDR_W-1:2] == (ADDR_W-2)'(`BIS_CONTROL_IDX)) begin
            return board_irq_pkg::SEL_CONTROL;
        end else begin
            return board_irq_pkg::SEL_NONE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic                     aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic                     awready_q, wready_q, arready_q;
    logic [1:0]               bresp_q, rresp_q;
    logic [31:0]              rdata_q;
    logic [7:0]               wbyte_q;
    logic                     wstrb0_q;
    board_irq_pkg::reg_sel_t  aw_sel_q;
    logic                     tc_en_q, won_en_q;
    logic [3:0]               cause_q;
    logic                     summary_q;
    logic                     rd_status_q;
    logic [2:0]               flag_q;

    ////////////////////////////////////////////////////////////////////////////
    // write channel

    logic aw_take, w_take, do_write, ctrl_wr;
    logic aw_full_d, w_full_d, bvalid_d;
    logic [1:0] bresp_d;
    board_irq_pkg::reg_sel_t aw_sel_d;

    assign aw_take   = awvalid && awready_q;
    assign w_take    = wvalid && wready_q;
    // address and data may arrive in either order; the write waits for both
    assign do_write  = aw_full_q && w_full_q && !bvalid_q;
    assign aw_full_d = aw_take || (aw_full_q && !do_write);
    assign w_full_d  = w_take || (w_full_q && !do_write);
    assign bvalid_d  = do_write || (bvalid_q && !bready);
    assign aw_sel_d  = aw_take ? decode(awaddr) : aw_sel_q;
    assign bresp_d   = !do_write ? bresp_q :
                       (aw_sel_q == board_irq_pkg::SEL_CONTROL) ? `BIS_RESP_OKAY : `BIS_RESP_SLVERR;
    // only the low byte holds enables; upper byte lanes are dropped
    assign ctrl_wr   = do_write && (aw_sel_q == board_irq_pkg::SEL_CONTROL) && wstrb0_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= `BIS_RESP_OKAY;
            aw_sel_q  <= board_irq_pkg::SEL_NONE;
            wbyte_q   <= 8'h00;
            wstrb0_q  <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready_q <= !aw_full_d;
            wready_q  <= !w_full_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            aw_sel_q  <= aw_sel_d;
            if (w_take) begin
                wbyte_q  <= wdata[7:0];
                wstrb0_q <= wstrb[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write-only control register

    logic tc_en_d, won_en_d;

    assign tc_en_d  = ctrl_wr ? wbyte_q[`BIS_CTRL_TC_EN_BIT] : tc_en_q;
    assign won_en_d = ctrl_wr ? wbyte_q[`BIS_CTRL_WON_EN_BIT] : won_en_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tc_en_q  <= `BIS_ENABLE_RESET;
            won_en_q <= `BIS_ENABLE_RESET;
        end else begin
            tc_en_q  <= tc_en_d;
            won_en_q <= won_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky flags: 0 bus won, 1 terminal count, 2 master exception

    logic ar_take, status_rd;
    logic [2:0] flag_en, flag_set, flag_clr;

    assign ar_take   = arvalid && arready_q;
    assign status_rd = ar_take && (decode(araddr) == board_irq_pkg::SEL_STATUS);

    // next enable is used so a clearing write empties the flag on the same edge
    assign flag_en[0]  = won_en_d;
    assign flag_set[0] = ev.arb_won_pulse;
    assign flag_clr[0] = 1'b0;
    assign flag_en[1]  = tc_en_d;
    assign flag_set[1] = ev.dma_tc_pulse;
    assign flag_clr[1] = 1'b0;
    // the whole word is read at once, so any status read also reads the cause byte
    assign flag_en[2]  = 1'b1;
    assign flag_set[2] = ev.exc_pulse;
    assign flag_clr[2] = status_rd;

    for (genvar i = 0; i < 3; i++) begin : g_flag
        event_flag u_flag (
            .aclk    (aclk),
            .aresetn (aresetn),
            .enable  (flag_en[i]),
            .set     (flag_set[i]),
            .clear   (flag_clr[i]),
            .flag_q  (flag_q[i])
        );
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause_q <= `BIS_CAUSE_RESET;
        end else if (ev.exc_pulse) begin
            cause_q <= ev.exc_cause;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status word and read channel

    board_irq_pkg::status_t st;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_d;
    logic        rvalid_d;
    board_irq_pkg::reg_sel_t ar_sel;

    assign st.signal_fifo_ready     = ev.sig_fifo_nonempty;
    assign st.bus_won_flag          = flag_q[0];
    assign st.terminal_count_flag   = flag_q[1];
    assign st.master_exception_flag = flag_q[2];
    assign st.remote_irq_seen       = ev.remote_irq;
    assign st.unused_5              = 1'b0;
    assign st.remote_irq_hi         = ev.remote_irq;
    assign st.board_irq_summary     = |st[6:0];
    assign st.exc_cause             = cause_q;

    assign ar_sel   = decode(araddr);
    assign rvalid_d = ar_take || (rvalid_q && !rready);
    // control is write-only and reads as zero; unmapped words answer slverr
    assign rdata_d  = !ar_take ? rdata_q :
                      (ar_sel == board_irq_pkg::SEL_STATUS) ? 32'(st) : 32'h0000_0000;
    assign rresp_d  = !ar_take ? rresp_q :
                      (ar_sel == board_irq_pkg::SEL_NONE) ? `BIS_RESP_SLVERR : `BIS_RESP_OKAY;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q   <= 1'b1;
            rvalid_q    <= 1'b0;
            rdata_q     <= `BIS_RDATA_RESET;
            rresp_q     <= `BIS_RESP_OKAY;
            rd_status_q <= 1'b0;
            summary_q   <= 1'b0;
        end else begin
            arready_q   <= !rvalid_d;
            rvalid_q    <= rvalid_d;
            rdata_q     <= rdata_d;
            rresp_q     <= rresp_d;
            rd_status_q <= ar_take ? status_rd : rd_status_q;
            summary_q   <= st.board_irq_summary;
        end
    end

    assign awready           = awready_q;
    assign wready            = wready_q;
    assign bvalid            = bvalid_q;
    assign bresp             = bresp_q;
    assign arready           = arready_q;
    assign rvalid            = rvalid_q;
    assign rdata             = rdata_q;
    assign rresp             = rresp_q;
    assign board_irq_summary = summary_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_remote_live: assert property (
        status_rd |=> rdata_q[4] == $past(ev.remote_irq))
        else $error("bit 4 does not show remote request");

    a_remote_mirror: assert property (
        rvalid_q && rd_status_q |-> rdata_q[6] == rdata_q[4])
        else $error("bits 4 and 6 differ");

    a_exc_set: assert property (
        ev.exc_pulse |=> flag_q[2] ##0 st.master_exception_flag)
        else $error("exception flag not set");

    a_exc_cause: assert property (
        ev.exc_pulse |=> cause_q == $past(ev.exc_cause))
        else $error("exception cause not recorded");

    a_exc_rd_clear: assert property (
        status_rd && !ev.exc_pulse |=> !flag_q[2])
        else $error("status read left exception flag set");

    a_tc_set: assert property (
        ev.dma_tc_pulse && tc_en_d |=> flag_q[1])
        else $error("terminal count flag not set");

    a_tc_clear: assert property (
        ctrl_wr && !wbyte_q[`BIS_CTRL_TC_EN_BIT] |=> !flag_q[1] && !tc_en_q)
        else $error("terminal count flag not cleared");

    a_won_set: assert property (
        ev.arb_won_pulse && won_en_d |=> flag_q[0])
        else $error("bus won flag not set");

    a_won_clear: assert property (
        ctrl_wr && !wbyte_q[`BIS_CTRL_WON_EN_BIT] |=> !flag_q[0] && !won_en_q)
        else $error("bus won flag not cleared");

    a_fifo_ready: assert property (
        status_rd |=> rdata_q[0] == $past(ev.sig_fifo_nonempty))
        else $error("bit 0 does not track fifo");

    a_fifo_empty: assert property (
        status_rd && !ev.sig_fifo_nonempty |=> !rdata_q[0])
        else $error("bit 0 set with empty fifo");

    a_summary_or: assert property (
        rvalid_q && rd_status_q |-> rdata_q[7] == (|rdata_q[6:0]))
        else $error("summary is not or of bits 6 to 0");

    a_ctrl_hold: assert property (
        !ctrl_wr |=> $stable(tc_en_q) && $stable(won_en_q))
        else $error("enable changed without control write");

    a_no_stale: assert property (
        (ctrl_wr && !wbyte_q[`BIS_CTRL_TC_EN_BIT]) ##[1:3] status_rd |=> !rdata_q[2])
        else $error("stale terminal count flag read");

    a_bvalid_hold: assert property (
        bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped early");

    c_exc_read: cover property (flag_q[2] ##0 status_rd);
    c_tc_set: cover property (ev.dma_tc_pulse && tc_en_q);
    c_won_set: cover property (ev.arb_won_pulse && won_en_q);
    c_ctrl_write: cover property (ctrl_wr && wbyte_q[`BIS_CTRL_TC_EN_BIT]);

endmodule

`default_nettype wire

// ---- verif/board_event_source.sv ----
// board-side event source model driven by bench commands
`timescale 1ns/1ns
`default_nettype none

module board_event_source (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // bench commands: 1 exception, 2 dma done, 3 arbitration won
    input  wire logic [1:0]             op,
    input  wire logic [3:0]             cause,
    input  wire logic                   irq_level,
    input  wire logic                   fifo_level,
    // board conditions
    output var  board_irq_pkg::events_t ev
);
    ////////////////////////////////////////////////////////////////////////
    // pulses last one cycle per command; cause is scrambled outside its pulse
    // so a design that samples it at the wrong time sees garbage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev <= '0;
        end else begin
            ev.remote_irq        <= irq_level;
            ev.exc_pulse         <= (op == 2'h1);
            ev.exc_cause         <= (op == 2'h1) ? cause : ~ev.exc_cause;
            ev.dma_tc_pulse      <= (op == 2'h2);
            ev.arb_won_pulse     <= (op == 2'h3);
            ev.sig_fifo_nonempty <= fifo_level;
        end
    end
endmodule

`default_nettype wire

// ---- verif/test_board_interrupt_status.sv ----
// self-checking bench for the board interrupt status block
`timescale 1ns/1ns
`default_nettype none
`include "board_irq_params.svh"

module test_board_interrupt_status;
    localparam logic [7:0] STAT_A = 8'(`BIS_STATUS_IDX * 4);
    localparam logic [7:0] CTRL_A = 8'(`BIS_CONTROL_IDX * 4);
    localparam logic [1:0] OKAY   = `BIS_RESP_OKAY;
    localparam logic [1:0] SLVERR = `BIS_RESP_SLVERR;

    logic                   aclk, aresetn;
    logic [7:0]             awaddr, araddr;
    logic [31:0]            wdata, rdata;
    logic [3:0]             wstrb, cause;
    logic [1:0]             bresp, rresp, op;
    logic                   awvalid, awready, wvalid, wready, bvalid, bready;
    logic                   arvalid, arready, rvalid, rready, summary, irq_level, fifo_level;
    board_irq_pkg::events_t ev;
    int                     n_mismatch, comparisons, cycles;
    logic [33:0]            rows [4];

    ////////////////////////////////////////////////////////////////////////
    board_interrupt_status #(.ADDR_W(8)) board_interrupt_status_inst (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ev(ev), .board_irq_summary(summary)
    );

    board_event_source board_event_source_inst (
        .aclk(aclk), .aresetn(aresetn), .op(op), .cause(cause),
        .irq_level(irq_level), .fifo_level(fifo_level), .ev(ev)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // run should need about 200 cycles; far beyond that is a hang
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // handshakes are judged mid-cycle, where the values the next edge samples are settled
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] exp_resp);
        logic aw_hs, w_hs, b_hs;
        logic [1:0] got;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        b_hs = 1'b0;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs  = wvalid && wready;
            b_hs  = bvalid;
            got   = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        check_word({30'h0, got}, {30'h0, exp_resp});
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] exp_data,
                            input logic [1:0] exp_resp);
        logic ar_hs, r_hs;
        logic [31:0] got;
        logic [1:0] gresp;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        r_hs = 1'b0;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs  = rvalid;
            got   = rdata;
            gresp = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        check_word(got, exp_data);
        check_word({30'h0, gresp}, {30'h0, exp_resp});
    endtask

    // one board event, then time for the flag and the summary to settle
    task automatic fire(input logic [1:0] o, input logic [3:0] c);
        @(posedge aclk);
        op    <= o;
        cause <= c;
        @(posedge aclk);
        op <= 2'h0;
        repeat (4) @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, irq_level, fifo_level} = 8'h00;
        {awaddr, araddr, wdata, wstrb, cause, op} = 58'h0;
        {n_mismatch, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
        // remote level, fifo level, expected status word
        rows = '{{2'b00, 32'h000}, {2'b10, 32'h0d0}, {2'b01, 32'h081}, {2'b11, 32'h0d1}};
        do_reset();
        @(negedge aclk);
        check_bit(awready && wready && arready, 1'b1);
        check_bit(bvalid || rvalid || summary, 1'b0);
        foreach (rows[i]) begin
            @(posedge aclk);
            {irq_level, fifo_level} <= rows[i][33:32];
            repeat (4) @(posedge aclk);
            axi_read(STAT_A, rows[i][31:0], OKAY);
            check_bit(summary, rows[i][7]);
        end
        @(posedge aclk);
        {irq_level, fifo_level} <= 2'b00;
        fire(2'h2, 4'h0);
        axi_read(STAT_A, 32'h000, OKAY);
        axi_write(CTRL_A, 32'h4, 4'h1, OKAY);
        fire(2'h2, 4'h0);
        axi_read(STAT_A, 32'h084, OKAY);
        check_bit(summary, 1'b1);
        axi_write(CTRL_A, 32'h6, 4'h0, OKAY);
        fire(2'h3, 4'h0);
        axi_read(STAT_A, 32'h084, OKAY);
        axi_write(CTRL_A, 32'h6, 4'h1, OKAY);
        fire(2'h3, 4'h0);
        axi_read(STAT_A, 32'h086, OKAY);
        axi_read(CTRL_A, 32'h0, OKAY);
        axi_write(CTRL_A, 32'h2, 4'h1, OKAY);
        axi_read(STAT_A, 32'h082, OKAY);
        axi_write(CTRL_A, 32'h0, 4'h1, OKAY);
        axi_read(STAT_A, 32'h000, OKAY);
        fire(2'h1, 4'ha);
        axi_read(STAT_A, 32'ha88, OKAY);
        axi_read(STAT_A, 32'ha00, OKAY);
        axi_write(STAT_A, 32'hff, 4'h1, SLVERR);
        axi_write(8'h30, 32'h6, 4'h1, SLVERR);
        axi_read(8'h30, 32'h0, SLVERR);
        axi_read(STAT_A, 32'ha00, OKAY);
        axi_write(CTRL_A, 32'h6, 4'h1, OKAY);
        fire(2'h2, 4'h0);
        fire(2'h3, 4'h0);
        do_reset();
        axi_read(STAT_A, 32'h000, OKAY);
        fire(2'h2, 4'h0);
        axi_read(STAT_A, 32'h000, OKAY);
        finish_test();
    end
endmodule

`default_nettype wire
